// ===== hdl/fus_pkg.sv
/*
  Shared constants for the flash unsecure and backdoor key command block:
  register offsets, field positions, command codes, key blank patterns and bus responses.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package fus_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_INDEX = 8'h04;
  localparam logic [7:0] ADDR_CMDWORD = 8'h08;
  localparam logic [7:0] ADDR_SECURITY = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h14;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h18;

  // ==========================================================
  // flash status register bit positions
  localparam int ST_CMD_DONE = 7;
  localparam int ST_ACC_ERR = 5;
  localparam int ST_PROT_VIOL = 4;
  localparam int ST_VERIFY_ERR = 1;
  localparam int ST_VERIFY_UNCORR = 0;

  // ==========================================================
  // security register fields
  localparam int SEC_STATE_LO = 0;
  localparam int KEY_EN_LO = 6;
  localparam int KEY_LOCK_BIT = 8;
  localparam logic [1:0] SEC_UNSECURED = 2'h2;
  localparam logic [1:0] KEY_EN_ON = 2'h2;

  // ==========================================================
  // command words and codes
  localparam int NUM_WORDS = 5;
  localparam logic [7:0] CMD_UNSECURE = 8'h0B;
  localparam logic [7:0] CMD_KEY_CHECK = 8'h0C;
  localparam logic [2:0] IDX_UNSECURE = 3'h0;
  localparam logic [2:0] IDX_KEY_CHECK = 3'h4;
  localparam logic [15:0] KEY_BLANK_LO = 16'h0000;
  localparam logic [15:0] KEY_BLANK_HI = 16'hFFFF;

  // ==========================================================
  // interrupt status layout and bus responses
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERROR = 1;
  localparam int IRQ_UNSEC = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== hdl/fus_exec_if.sv
/*
  Interface between the command front end and the executor.
  Assumes both ends share one clock; results are valid with done.
*/
`timescale 1ns/1ps
interface fus_exec_if;
  logic start;
  logic [7:0] cmd;
  logic [63:0] keys;
  logic done;
  logic verify_fail;
  logic verify_uncorr;
  logic key_match;

  modport ctl (output start, output cmd, output keys,
               input done, input verify_fail, input verify_uncorr, input key_match);
  modport exe (input start, input cmd, input keys,
               output done, output verify_fail, output verify_uncorr, output key_match);
endinterface

// ===== hdl/fus_exec.sv
/*
  Command executor: runs erase then verify for the unsecure command and
  the key comparison for the backdoor check.
  Assumes the array answers erase and verify requests with done pulses.
*/
`timescale 1ns/1ps
module fus_exec
  import fus_pkg::*;
(
  input wire clk,
  input wire resetn,
  fus_exec_if.exe ex,
  output logic erase_req,
  input wire erase_done,
  output logic verify_req,
  input wire verify_done,
  input wire verify_blank,
  input wire verify_uncorr,
  input wire [63:0] stored_keys,
  output logic array_read_block
);

  typedef enum logic [1:0] {X_IDLE, X_ERASE, X_VERIFY, X_KEY} fus_xstate_e;

  typedef struct packed {
    fus_xstate_e st;
    logic done;
    logic vfail;
    logic vuncorr;
    logic match;
  } fus_exec_s;

  fus_exec_s q;
  fus_exec_s d;

  // keys pass only if equal and no stored key is a blank pattern
  function automatic logic keys_ok(input logic [63:0] given, input logic [63:0] stored);
    logic ok;
    ok = (given == stored);
    for (int i = 0; i < 4; i++) begin
      if (stored[i*16 +: 16] == KEY_BLANK_LO || stored[i*16 +: 16] == KEY_BLANK_HI) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  // ==========================================================
  // sequencing
  always_comb begin
    d = q;
    d.done = 1'b0;
    case (q.st)
      X_IDLE: begin
        if (ex.start) begin
          if (ex.cmd == CMD_UNSECURE) begin
            d.st = X_ERASE;
          end else if (ex.cmd == CMD_KEY_CHECK) begin
            d.st = X_KEY;
          end else begin
            d.done = 1'b1;
          end
        end
      end
      X_ERASE: begin
        if (erase_done) begin
          d.st = X_VERIFY;
        end
      end
      X_VERIFY: begin
        if (verify_done) begin
          d.vfail = !verify_blank;
          d.vuncorr = verify_uncorr;
          d.done = 1'b1;
          d.st = X_IDLE;
        end
      end
      X_KEY: begin
        d.match = keys_ok(ex.keys, stored_keys);
        d.done = 1'b1;
        d.st = X_IDLE;
      end
      default: begin
        d.st = X_IDLE;
      end
    endcase
    if (!resetn) begin
      d = '0;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  // handshake levels straight from state
  assign erase_req = (q.st == X_ERASE);
  assign verify_req = (q.st == X_VERIFY);
  assign array_read_block = (q.st == X_KEY);
  assign ex.done = q.done;
  assign ex.verify_fail = q.vfail;
  assign ex.verify_uncorr = q.vuncorr;
  assign ex.key_match = q.match;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  erase_first_a: assert property (ex.start && q.st == X_IDLE && ex.cmd == CMD_UNSECURE |=> erase_req)
    else $error("erase did not start");
  verify_next_a: assert property (erase_req && erase_done |=> verify_req && !erase_req)
    else $error("verify did not follow erase");
  key_block_a: assert property (ex.start && q.st == X_IDLE && ex.cmd == CMD_KEY_CHECK
                                |=> array_read_block ##1 ex.done && !array_read_block)
    else $error("array reads not blocked during key check");
  key_result_a: assert property (q.st == X_KEY |=> ex.key_match == $past(keys_ok(ex.keys, stored_keys)))
    else $error("key match result wrong");
  erase_cov_c: cover property (verify_req && verify_done && verify_blank);
  key_cov_c: cover property (q.st == X_KEY ##1 ex.key_match);

endmodule

// ===== hdl/fus_top.sv
/*
  Flash security command sequencer with an AXI4-Lite register slave:
  command words, status flags, security state and an interrupt.
  Assumes the array, protection and mode inputs are synchronous to clk
  and that the security byte strap is stable at reset release.
*/
// Functional notes
// - code 0x0B plus done-flag clear launches unsecure
// - unsecure erases whole array then verifies it
// - blank verify releases security at end
// - failed verify sets error, security kept
// - done flag returns when operation finishes
// - word index other than 0 (unsecure) or 4 (key check) at launch: access error
// - command barred in mode: access error
// - any protected area at unsecure launch: protection violation
// - uncorrectable read during verify sets flag
// - key check needs key enable field on
// - matching keys release security
// - key success forces state field to 10
// - wrong key locks checks until reset
// - array reads invalid during key check
`timescale 1ns/1ps
module fus_top
  import fus_pkg::*;
(
  input wire clk,
  input wire resetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output logic s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire s_axi_rready,
  output logic irq,
  input wire [7:0] sec_byte_in,
  input wire cmd_allowed,
  input wire protect_any,
  input wire [63:0] stored_keys,
  output logic erase_req,
  input wire erase_done,
  output logic verify_req,
  input wire verify_done,
  input wire verify_blank,
  input wire verify_uncorr,
  output logic array_read_block,
  output logic [1:0] security_state,
  output logic cmd_busy
);

  typedef struct packed {
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic cmd_complete_flag;
    logic access_error_flag;
    logic protect_violation_flag;
    logic verify_error_flag;
    logic verify_uncorrectable_flag;
    logic [2:0] cmd_word_index;
    logic [NUM_WORDS-1:0][15:0] cmd_word_array;
    logic [1:0] security_state_field;
    logic [1:0] key_enable_field;
    logic sec_loaded;
    logic key_lock;
    logic busy;
    logic start;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_en;
  } fus_regs_s;

  fus_regs_s q;
  fus_regs_s d;

  fus_exec_if ex_if ();

  logic do_wr;
  logic launch;
  logic [7:0] cur_cmd;
  logic err_acc;
  logic err_prot;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  // byte-lane merge of a 16-bit command word
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
    return {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
  endfunction

  // ==========================================================
  // executor
  fus_exec u_exec (
    .clk(clk),
    .resetn(resetn),
    .ex(ex_if.exe),
    .erase_req(erase_req),
    .erase_done(erase_done),
    .verify_req(verify_req),
    .verify_done(verify_done),
    .verify_blank(verify_blank),
    .verify_uncorr(verify_uncorr),
    .stored_keys(stored_keys),
    .array_read_block(array_read_block)
  );

  assign ex_if.start = q.start;
  assign ex_if.cmd = q.cmd_word_array[0][7:0];
  assign ex_if.keys = {q.cmd_word_array[4], q.cmd_word_array[3], q.cmd_word_array[2], q.cmd_word_array[1]};

  // ==========================================================
  // bus, launch checks, completion and interrupt state
  always_comb begin
    d = q;
    do_wr = 1'b0;
    launch = 1'b0;
    err_acc = 1'b0;
    err_prot = 1'b0;
    irq_set = '0;
    irq_clr = '0;
    cur_cmd = q.cmd_word_array[0][7:0];
    d.start = 1'b0;

    // strap capture one cycle after reset release, never under reset
    if (!q.sec_loaded) begin
      d.security_state_field = sec_byte_in[SEC_STATE_LO +: 2];
      d.key_enable_field = sec_byte_in[KEY_EN_LO +: 2];
      d.sec_loaded = 1'b1;
    end

    // response retire
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end

    // address and data are latched independently, in either order
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_got = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_got = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end

    // read mux, answered in the cycle after the address is taken
    if (s_axi_arvalid && s_axi_arready) begin
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      d.rdata = '0;
      case (s_axi_araddr)
        ADDR_STATUS: begin
          d.rdata[ST_CMD_DONE] = q.cmd_complete_flag;
          d.rdata[ST_ACC_ERR] = q.access_error_flag;
          d.rdata[ST_PROT_VIOL] = q.protect_violation_flag;
          d.rdata[ST_VERIFY_ERR] = q.verify_error_flag;
          d.rdata[ST_VERIFY_UNCORR] = q.verify_uncorrectable_flag;
        end
        ADDR_INDEX: d.rdata[2:0] = q.cmd_word_index;
        ADDR_CMDWORD: begin
          if (q.cmd_word_index < NUM_WORDS) begin
            d.rdata[15:0] = q.cmd_word_array[q.cmd_word_index];
          end
        end
        ADDR_SECURITY: begin
          d.rdata[SEC_STATE_LO +: 2] = q.security_state_field;
          d.rdata[KEY_EN_LO +: 2] = q.key_enable_field;
          d.rdata[KEY_LOCK_BIT] = q.key_lock;
        end
        ADDR_IRQ_STAT: d.rdata[IRQ_W-1:0] = q.irq_st;
        ADDR_IRQ_CLR: d.rdata = '0;
        ADDR_IRQ_EN: d.rdata[IRQ_W-1:0] = q.irq_en;
        default: d.rresp = RESP_SLVERR;
      endcase
    end

    // write execution once both halves are held
    if (q.aw_got && q.w_got && !q.bvalid) begin
      do_wr = 1'b1;
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      // flash registers ignore writes while busy; host keeps off them anyway
      case (q.aw_addr)
        ADDR_STATUS: begin
          if (!q.busy && q.w_strb[0]) begin
            if (q.w_data[ST_ACC_ERR]) begin
              d.access_error_flag = 1'b0;
            end
            if (q.w_data[ST_PROT_VIOL]) begin
              d.protect_violation_flag = 1'b0;
            end
            launch = q.w_data[ST_CMD_DONE] && q.cmd_complete_flag && q.sec_loaded;
          end
        end
        ADDR_INDEX: begin
          if (!q.busy && q.w_strb[0]) begin
            d.cmd_word_index = q.w_data[2:0];
          end
        end
        ADDR_CMDWORD: begin
          if (!q.busy && q.cmd_word_index < NUM_WORDS) begin
            d.cmd_word_array[q.cmd_word_index] = merge16(q.cmd_word_array[q.cmd_word_index], q.w_data, q.w_strb);
          end
        end
        ADDR_SECURITY: d.bresp = RESP_OKAY;
        ADDR_IRQ_STAT: d.bresp = RESP_OKAY;
        ADDR_IRQ_CLR: begin
          if (q.w_strb[0]) begin
            irq_clr = q.w_data[IRQ_W-1:0];
          end
        end
        ADDR_IRQ_EN: begin
          if (q.w_strb[0]) begin
            d.irq_en = q.w_data[IRQ_W-1:0];
          end
        end
        default: d.bresp = RESP_SLVERR;
      endcase
    end

    // launch checks; flags set after the clear above so a set wins
    if (launch) begin
      case (cur_cmd)
        CMD_UNSECURE: begin
          err_acc = (q.cmd_word_index != IDX_UNSECURE) || !cmd_allowed;
          err_prot = protect_any;
        end
        CMD_KEY_CHECK: begin
          err_acc = (q.cmd_word_index != IDX_KEY_CHECK) || !cmd_allowed
                    || (q.key_enable_field != KEY_EN_ON) || q.key_lock;
        end
        default: err_acc = 1'b1;
      endcase
      if (err_acc || err_prot) begin
        // done flag never drops, nothing reaches the executor
        d.access_error_flag = q.access_error_flag || err_acc;
        d.protect_violation_flag = q.protect_violation_flag || err_prot;
        irq_set[IRQ_DONE] = 1'b1;
        irq_set[IRQ_ERROR] = 1'b1;
      end else begin
        d.cmd_complete_flag = 1'b0;
        d.busy = 1'b1;
        d.start = 1'b1;
        d.verify_error_flag = 1'b0;
        d.verify_uncorrectable_flag = 1'b0;
      end
    end

    // completion from the executor
    if (ex_if.done && q.busy) begin
      d.cmd_complete_flag = 1'b1;
      d.busy = 1'b0;
      irq_set[IRQ_DONE] = 1'b1;
      if (cur_cmd == CMD_UNSECURE) begin
        d.verify_error_flag = ex_if.verify_fail;
        d.verify_uncorrectable_flag = ex_if.verify_uncorr;
        if (!ex_if.verify_fail) begin
          d.security_state_field = SEC_UNSECURED;
          irq_set[IRQ_UNSEC] = 1'b1;
        end else begin
          irq_set[IRQ_ERROR] = 1'b1;
        end
      end else if (ex_if.key_match) begin
        // stored security byte is untouched, only the live field moves
        d.security_state_field = SEC_UNSECURED;
        irq_set[IRQ_UNSEC] = 1'b1;
      end else begin
        d.key_lock = 1'b1;
        irq_set[IRQ_ERROR] = 1'b1;
      end
    end

    // sticky interrupt status, a simultaneous event beats the clear
    d.irq_st = (q.irq_st & ~irq_clr) | irq_set;

    if (!resetn) begin
      d = '0;
      d.cmd_complete_flag = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  // ==========================================================
  // outputs
  assign s_axi_awready = !q.aw_got && !q.bvalid;
  assign s_axi_wready = !q.w_got && !q.bvalid;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign irq = |(q.irq_st & q.irq_en);
  assign security_state = q.security_state_field;
  assign cmd_busy = q.busy;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  launch_start_a: assert property (launch && !err_acc && !err_prot
                                   |=> !q.cmd_complete_flag && q.start ##1 !q.start)
    else $error("accepted launch did not start the executor");
  done_return_a: assert property (ex_if.done && q.busy |=> q.cmd_complete_flag && !q.busy)
    else $error("done flag not restored at completion");
  index_err_a: assert property (launch && cur_cmd == CMD_UNSECURE && q.cmd_word_index != IDX_UNSECURE
                                |=> q.access_error_flag && q.cmd_complete_flag && !q.start)
    else $error("bad word index not refused");
  mode_err_a: assert property (launch && !cmd_allowed |=> q.access_error_flag && !q.busy)
    else $error("barred command not refused");
  prot_err_a: assert property (launch && cur_cmd == CMD_UNSECURE && protect_any
                               |=> q.protect_violation_flag && q.cmd_complete_flag)
    else $error("protection violation not flagged");
  verify_fail_a: assert property (ex_if.done && q.busy && cur_cmd == CMD_UNSECURE && ex_if.verify_fail
                                  |=> q.verify_error_flag && $stable(q.security_state_field))
    else $error("failed verify changed security or missed flag");
  unsec_ok_a: assert property (ex_if.done && q.busy && cur_cmd == CMD_UNSECURE && !ex_if.verify_fail
                               |=> security_state == SEC_UNSECURED)
    else $error("blank verify did not release security");
  uncorr_a: assert property (ex_if.done && q.busy && cur_cmd == CMD_UNSECURE
                             |=> q.verify_uncorrectable_flag == $past(ex_if.verify_uncorr))
    else $error("uncorrectable flag wrong");
  key_enable_field_a: assert property (launch && cur_cmd == CMD_KEY_CHECK && q.key_enable_field != KEY_EN_ON
                            |=> !q.busy && q.access_error_flag)
    else $error("key check ran while disabled");
  key_lock_a: assert property (q.key_lock && launch |=> !(q.busy && cur_cmd == CMD_KEY_CHECK))
    else $error("key check ran after lockout");
  key_ok_a: assert property (ex_if.done && q.busy && cur_cmd == CMD_KEY_CHECK && ex_if.key_match
                             |=> security_state == SEC_UNSECURED && !q.key_lock)
    else $error("matching keys did not unsecure");
  unsec_cov_c: cover property (launch && cur_cmd == CMD_UNSECURE ##[1:50] q.cmd_complete_flag && !q.verify_error_flag);
  key_pass_c: cover property (launch && cur_cmd == CMD_KEY_CHECK ##[1:5] ex_if.key_match);
  key_fail_c: cover property (q.key_lock && launch);
  irq_cov_c: cover property (irq);

endmodule

// ===== test/fus_top_test.sv
/*
  Self-checking bench for fus_top: a register bus master, a small array responder and scenario tasks.
  Assumes the register map and field positions of fus_pkg and a 25 MHz clock.
*/
`timescale 1ns/1ps
module fus_top_test;
  import fus_pkg::*;
  // ==========================================================
  // signals and expected constants
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, sec_byte_in = 8'h80;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, erase_req, verify_req;
  logic array_read_block, cmd_busy;
  logic [1:0] s_axi_bresp, s_axi_rresp, security_state, resp;
  logic cmd_allowed = 1'b1, protect_any = 1'b0, erase_done = 1'b0, verify_done = 1'b0;
  logic verify_blank = 1'b1, verify_uncorr = 1'b0;
  localparam logic [63:0] KEYS = 64'h4444_3333_2222_1111;
  logic [63:0] stored_keys = KEYS;
  int num_errors = 0, tests_run = 0, cyc = 0, n_erase = 0, n_blk = 0, ecnt = 0, vcnt = 0;
  localparam logic [31:0] DN = 32'h1 << ST_CMD_DONE, AE = 32'h1 << ST_ACC_ERR, PV = 32'h1 << ST_PROT_VIOL;
  localparam logic [31:0] VE = 32'h1 << ST_VERIFY_ERR, VU = 32'h1 << ST_VERIFY_UNCORR;

  fus_top uut (.*);

  // clock and a hang limit well above the expected run
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end

  // ==========================================================
  // array responder: stalls three cycles so the requests must hold
  always @(posedge clk) begin
    erase_done <= erase_req && !erase_done && ecnt == 3;
    ecnt <= (erase_req && !erase_done && ecnt != 3) ? ecnt + 1 : 0;
    verify_done <= verify_req && !verify_done && vcnt == 3;
    vcnt <= (verify_req && !verify_done && vcnt != 3) ? vcnt + 1 : 0;
    if (erase_req && !erase_done && ecnt == 3) n_erase <= n_erase + 1;
    if (array_read_block) n_blk <= n_blk + 1;
  end

  // ==========================================================
  // bus master; handshakes are looked at on the falling edge, which shows what the next rising edge samples
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    b = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b) begin
      @(negedge clk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a);
    logic ar, r;
    r = 1'b0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r) begin
      @(negedge clk);
      ar = s_axi_arvalid && s_axi_arready;
      r = s_axi_rvalid;
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask

  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // load code and keys, set the index, clear old errors, launch, then only read until done
  task automatic run(input logic [7:0] code, input logic [2:0] idx, input logic [63:0] k);
    wr(ADDR_INDEX, 32'h0);
    wr(ADDR_CMDWORD, {24'h0, code});
    for (int i = 1; i < NUM_WORDS; i++) begin
      wr(ADDR_INDEX, i);
      wr(ADDR_CMDWORD, {16'h0, k[16*i-16 +: 16]});
    end
    wr(ADDR_INDEX, {29'h0, idx});
    wr(ADDR_STATUS, AE | PV);
    wr(ADDR_STATUS, DN);
    rdr(ADDR_STATUS);
    repeat (40) if (rd[ST_CMD_DONE] !== 1'b1) rdr(ADDR_STATUS);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset(input logic [7:0] strap);
    @(posedge clk);
    sec_byte_in <= strap;
    resetn <= 1'b0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    rdr(ADDR_STATUS);
    chk("status at reset", rd, DN);
    rdr(ADDR_SECURITY);
    chk("security at reset", rd, {24'h0, strap});
    chk("read resp", resp, RESP_OKAY);
  endtask

  task automatic t_bus;
    wr(8'h40, 32'h1);
    chk("unmapped write resp", resp, RESP_SLVERR);
    rdr(8'h40);
    chk("unmapped read data", rd, 32'h0);
    chk("unmapped read resp", resp, RESP_SLVERR);
  endtask

  task automatic t_refuse;
    run(CMD_UNSECURE, 3'h1, KEYS);
    chk("index refused", rd, DN | AE);
    cmd_allowed <= 1'b0;
    run(CMD_UNSECURE, IDX_UNSECURE, KEYS);
    chk("mode refused", rd, DN | AE);
    cmd_allowed <= 1'b1;
    protect_any <= 1'b1;
    run(CMD_UNSECURE, IDX_UNSECURE, KEYS);
    chk("protect refused", rd, DN | PV);
    protect_any <= 1'b0;
    chk("no erase on refusal", n_erase, 32'h0);
  endtask

  task automatic t_irq;
    wr(ADDR_IRQ_CLR, 32'h7);
    wr(ADDR_IRQ_EN, 32'h0);
    run(8'h55, IDX_UNSECURE, KEYS);
    rdr(ADDR_IRQ_STAT);
    chk("irq events", rd, (32'h1 << IRQ_DONE) | (32'h1 << IRQ_ERROR));
    chk("irq masked", irq, 1'b0);
    wr(ADDR_IRQ_EN, 32'h1 << IRQ_ERROR);
    chk("write resp", resp, RESP_OKAY);
    chk("irq raised", irq, 1'b1);
    wr(ADDR_IRQ_CLR, 32'h1 << IRQ_ERROR);
    chk("irq cleared", irq, 1'b0);
  endtask

  // the failing verify comes first so that the passing one must clear its flags
  task automatic t_unsecure;
    verify_blank <= 1'b0;
    verify_uncorr <= 1'b1;
    run(CMD_UNSECURE, IDX_UNSECURE, KEYS);
    chk("verify failed", rd, DN | VE | VU);
    chk("state kept", security_state, 2'h0);
    chk("erase once", n_erase, 32'h1);
    verify_blank <= 1'b1;
    verify_uncorr <= 1'b0;
    run(CMD_UNSECURE, IDX_UNSECURE, KEYS);
    chk("verify passed", rd, DN);
    chk("state released", security_state, SEC_UNSECURED);
    chk("erase twice", n_erase, 32'h2);
    chk("idle after done", cmd_busy, 1'b0);
    rdr(ADDR_IRQ_STAT);
    chk("unsecure event", rd, (32'h1 << IRQ_DONE) | (32'h1 << IRQ_ERROR) | (32'h1 << IRQ_UNSEC));
  endtask

  task automatic t_keys;
    int blk0;
    t_reset(8'h40);
    run(CMD_KEY_CHECK, IDX_KEY_CHECK, KEYS);
    chk("keys disabled", rd, DN | AE);
    t_reset({KEY_EN_ON, 6'h0});
    run(CMD_KEY_CHECK, IDX_KEY_CHECK, ~KEYS);
    rdr(ADDR_SECURITY);
    chk("wrong key locks", rd, {23'h0, 1'b1, KEY_EN_ON, 6'h0});
    run(CMD_KEY_CHECK, IDX_KEY_CHECK, KEYS);
    chk("locked refused", rd, DN | AE);
    chk("still secured", security_state, 2'h0);
    t_reset({KEY_EN_ON, 6'h0});
    blk0 = n_blk;
    run(CMD_KEY_CHECK, IDX_KEY_CHECK, KEYS);
    chk("key match", rd, DN);
    chk("state forced", security_state, SEC_UNSECURED);
    chk("reads blocked", n_blk - blk0, 32'h1);
  endtask

  task report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    t_reset(8'h80);
    t_bus();
    t_refuse();
    t_irq();
    t_unsecure();
    t_keys();
    report_and_stop();
  end
endmodule
